//--- design/wcec_pkg.sv
// Behaviour
// - Undervoltage enters power-fail, code 076, weight invalid
// - Command wrong for present mode gets 100
// - Value above parameter maximum gets 101
// - Value below parameter minimum gets 102
// - Illegal Modbus start address gets 103
// - Illegal Modbus register count gets 104
// - Illegal register data or panel value gets 105
// - Command while previous pending gets 106, comms only
// - Zero needs stable weight, else 110
// - With guard on, unstable tare/print gets 110
// - Unipolar tare at negative gross gets 111
// - Zero in net mode gets 112
package wcec_pkg;

    localparam int ADDR_W = 8;

    // Register byte offsets
    localparam logic [7:0] OFF_CTRL   = 8'h00;
    localparam logic [7:0] OFF_STATUS = 8'h04;
    localparam logic [7:0] OFF_RESULT = 8'h08;
    localparam logic [7:0] OFF_CMD    = 8'h0c;
    localparam logic [7:0] OFF_PARAM  = 8'h10;
    localparam logic [7:0] OFF_LIMIT  = 8'h14;
    localparam logic [7:0] OFF_MBADR  = 8'h18;
    localparam logic [7:0] OFF_MBDAT  = 8'h1c;
    localparam logic [7:0] OFF_PVAL   = 8'h20;

    // Control register fields
    localparam int          CTRL_W        = 11;
    localparam int          CTRL_GUARD    = 0;
    localparam int          CTRL_UNIPOLAR = 1;
    localparam int          CTRL_SETUP    = 2;
    localparam int          CTRL_SEL_LSB  = 8;
    localparam logic [10:0] CTRL_RST      = 11'h000;

    // Status register fields
    localparam int ST_PF     = 0;
    localparam int ST_VALID  = 1;
    localparam int ST_NET    = 2;
    localparam int ST_BUSY   = 3;
    localparam int ST_STABLE = 4;

    // Request word layouts
    localparam int CMD_SRC     = 8;
    localparam int VAL_W       = 16;
    localparam int PAR_IDX_LSB = 16;
    localparam int PAR_IDX_W   = 3;
    localparam int MB_CNT_LSB  = 16;
    localparam int MB_CNT_W    = 8;
    localparam int MBADR_W     = 24;
    localparam int MB_MAX_REGS = 1;

    // Error codes, decimal values in hex
    localparam logic [7:0] ERR_NONE     = 8'h00;
    localparam logic [7:0] ERR_PWR_FAIL = 8'h4c;
    localparam logic [7:0] ERR_STATE    = 8'h64;
    localparam logic [7:0] ERR_HIGH     = 8'h65;
    localparam logic [7:0] ERR_LOW      = 8'h66;
    localparam logic [7:0] ERR_START    = 8'h67;
    localparam logic [7:0] ERR_COUNT    = 8'h68;
    localparam logic [7:0] ERR_FAULTY   = 8'h69;
    localparam logic [7:0] ERR_PENDING  = 8'h6a;
    localparam logic [7:0] ERR_UNSTABLE = 8'h6e;
    localparam logic [7:0] ERR_NEG_TARE = 8'h6f;
    localparam logic [7:0] ERR_NET_MODE = 8'h70;

    typedef enum logic [2:0] {
        OP_NONE  = 3'h0,
        OP_ZERO  = 3'h1,
        OP_TARE  = 3'h2,
        OP_PRINT = 3'h3,
        OP_GROSS = 3'h4,
        OP_NET   = 3'h5
    } wcec_op_t;

    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    function automatic logic wcec_readable(input logic [ADDR_W-1:0] a);
        return (a == OFF_CTRL) || (a == OFF_STATUS) || (a == OFF_RESULT) ||
               (a == OFF_MBADR) || (a == OFF_PVAL) || (a == OFF_CMD) ||
               (a == OFF_PARAM) || (a == OFF_LIMIT) || (a == OFF_MBDAT);
    endfunction : wcec_readable

    function automatic logic wcec_writable(input logic [ADDR_W-1:0] a);
        return (a == OFF_CTRL) || (a == OFF_CMD) || (a == OFF_PARAM) ||
               (a == OFF_LIMIT) || (a == OFF_MBADR) || (a == OFF_MBDAT);
    endfunction : wcec_writable

endpackage : wcec_pkg

//--- design/wcec_axil.sv
module wcec_axil (
    // Clock and reset
    input  wire logic                       aclk,
    input  wire logic                       aresetn,
    // AXI4-Lite write
    input  wire logic [wcec_pkg::ADDR_W-1:0] awaddr,
    input  wire logic                       awvalid,
    output logic                            awready,
    input  wire logic [31:0]                wdata,
    input  wire logic [3:0]                 wstrb,
    input  wire logic                       wvalid,
    output logic                            wready,
    output logic [1:0]                      bresp,
    output logic                            bvalid,
    input  wire logic                       bready,
    // AXI4-Lite read
    input  wire logic [wcec_pkg::ADDR_W-1:0] araddr,
    input  wire logic                       arvalid,
    output logic                            arready,
    output logic [31:0]                     rdata,
    output logic [1:0]                      rresp,
    output logic                            rvalid,
    input  wire logic                       rready,
    // Register side
    output logic                            wr_en,
    output logic [wcec_pkg::ADDR_W-1:0]     wr_addr,
    output logic [31:0]                     wr_data,
    output logic [3:0]                      wr_strb,
    input  wire logic [31:0]                rd_data
);
    import wcec_pkg::*;

    typedef struct packed {
        logic              aw_full;
        logic              w_full;
        logic              awready;
        logic              wready;
        logic              bvalid;
        logic [1:0]        bresp;
        logic              arready;
        logic              rvalid;
        logic [31:0]       rdata;
        logic [1:0]        rresp;
        logic              wr_en;
        logic [ADDR_W-1:0] wr_addr;
        logic [31:0]       wr_data;
        logic [3:0]        wr_strb;
    } wcec_axil_t;

    wcec_axil_t st_reg;
    wcec_axil_t st_next;

    always_comb begin
        st_next       = st_reg;
        st_next.wr_en = 1'b0;
        // Address and data are taken in either order
        if (awvalid && st_reg.awready) begin
            st_next.aw_full = 1'b1;
            st_next.wr_addr = awaddr;
        end
        if (wvalid && st_reg.wready) begin
            st_next.w_full  = 1'b1;
            st_next.wr_data = wdata;
            st_next.wr_strb = wstrb;
        end
        if (st_reg.bvalid && bready) begin
            st_next.bvalid = 1'b0;
        end
        if (st_reg.aw_full && st_reg.w_full && !st_reg.bvalid) begin
            st_next.aw_full = 1'b0;
            st_next.w_full  = 1'b0;
            st_next.wr_en   = wcec_writable(st_reg.wr_addr);
            st_next.bvalid  = 1'b1;
            st_next.bresp   = wcec_writable(st_reg.wr_addr) ? RESP_OKAY : RESP_SLVERR;
        end
        // Ready stays low until the response drains, so one write at a time
        st_next.awready = !st_next.aw_full && !st_next.bvalid && !st_next.wr_en;
        st_next.wready  = !st_next.w_full && !st_next.bvalid && !st_next.wr_en;
        if (st_reg.rvalid && rready) begin
            st_next.rvalid = 1'b0;
        end
        if (arvalid && st_reg.arready) begin
            st_next.rvalid = 1'b1;
            st_next.rdata  = wcec_readable(araddr) ? rd_data : 32'h0000_0000;
            st_next.rresp  = wcec_readable(araddr) ? RESP_OKAY : RESP_SLVERR;
        end
        st_next.arready = !st_next.rvalid && !(arvalid && st_reg.arready);
        if (!aresetn) begin
            st_next = '0;
        end
    end

    always_ff @(posedge aclk) begin
        st_reg <= st_next;
    end

    assign awready = st_reg.awready;
    assign wready  = st_reg.wready;
    assign bvalid  = st_reg.bvalid;
    assign bresp   = st_reg.bresp;
    assign arready = st_reg.arready;
    assign rvalid  = st_reg.rvalid;
    assign rdata   = st_reg.rdata;
    assign rresp   = st_reg.rresp;
    assign wr_en   = st_reg.wr_en;
    assign wr_addr = st_reg.wr_addr;
    assign wr_data = st_reg.wr_data;
    assign wr_strb = st_reg.wr_strb;

endmodule : wcec_axil

//--- design/wcec_judge.sv
module wcec_judge (
    // Command request
    input  wire logic                  req_cmd,
    input  wire wcec_pkg::wcec_op_t    op,
    input  wire logic                  from_comm,
    // Instrument state
    input  wire logic                  pwr_fail,
    input  wire logic                  setup_mode,
    input  wire logic                  busy,
    input  wire logic                  net_mode,
    input  wire logic                  stable,
    input  wire logic                  guard,
    input  wire logic                  unipolar,
    input  wire logic                  gross_neg,
    // Verdict
    output logic [7:0]                 code
);
    import wcec_pkg::*;

    always_comb begin
        code = ERR_NONE;
        if (req_cmd) begin
            if (pwr_fail || setup_mode || op == OP_NONE || op > OP_NET) begin
                code = ERR_STATE;
            end else if (busy) begin
                // The panel never sees the pending code
                code = from_comm ? ERR_PENDING : ERR_STATE;
            end else begin
                case (op)
                    OP_ZERO: begin
                        if (net_mode) begin
                            code = ERR_NET_MODE;
                        end else if (!stable) begin
                            code = ERR_UNSTABLE;
                        end
                    end
                    OP_TARE: begin
                        if (guard && !stable) begin
                            code = ERR_UNSTABLE;
                        end else if (unipolar && gross_neg) begin
                            code = ERR_NEG_TARE;
                        end
                    end
                    OP_PRINT: begin
                        if (guard && !stable) begin
                            code = ERR_UNSTABLE;
                        end
                    end
                    default: begin
                        code = ERR_NONE;
                    end
                endcase
            end
        end
    end

endmodule : wcec_judge

//--- design/wcec_top.sv
module wcec_top #(
    parameter int          NPARAM  = 8,
    parameter logic [15:0] MB_BASE = 16'h0100
) (
    // Clock and reset
    input  wire logic                       aclk,
    input  wire logic                       aresetn,
    // AXI4-Lite write
    input  wire logic [wcec_pkg::ADDR_W-1:0] awaddr,
    input  wire logic                       awvalid,
    output logic                            awready,
    input  wire logic [31:0]                wdata,
    input  wire logic [3:0]                 wstrb,
    input  wire logic                       wvalid,
    output logic                            wready,
    output logic [1:0]                      bresp,
    output logic                            bvalid,
    input  wire logic                       bready,
    // AXI4-Lite read
    input  wire logic [wcec_pkg::ADDR_W-1:0] araddr,
    input  wire logic                       arvalid,
    output logic                            arready,
    output logic [31:0]                     rdata,
    output logic [1:0]                      rresp,
    output logic                            rvalid,
    input  wire logic                       rready,
    // Weighing front end
    input  wire logic                       undervolt,
    input  wire logic                       weight_stable,
    input  wire logic                       gross_neg,
    input  wire logic                       cmd_done,
    // Instrument status
    output logic                            pwr_fail,
    output logic                            weight_valid,
    output logic                            net_mode,
    output logic                            busy,
    output logic [7:0]                      err_code,
    output logic                            err_pulse,
    // Accepted command to the weighing engine
    output logic                            cmd_go,
    output wcec_pkg::wcec_op_t              cmd_op,
    // Accepted parameter update
    output logic                            param_upd,
    output logic [wcec_pkg::PAR_IDX_W-1:0]  param_idx,
    output logic [15:0]                     param_val
);
    import wcec_pkg::*;

    localparam logic [16:0] MB_END = 17'(MB_BASE) + 17'(NPARAM);

    typedef struct packed {
        logic [CTRL_W-1:0]                ctrl;
        logic [MBADR_W-1:0]               mbadr;
        logic                             pf;
        logic                             wv;
        logic                             net;
        logic                             busy;
        logic [7:0]                       code;
        logic                             err;
        logic                             go;
        wcec_op_t                         op;
        logic                             upd;
        logic [PAR_IDX_W-1:0]             pidx;
        logic [VAL_W-1:0]                 pval_o;
        logic [NPARAM-1:0][VAL_W-1:0]     pv;
        logic [NPARAM-1:0][VAL_W-1:0]     pmin;
        logic [NPARAM-1:0][VAL_W-1:0]     pmax;
    } wcec_state_t;

    wcec_state_t st_reg;
    wcec_state_t st_next;

    logic                  wr_en;
    logic [ADDR_W-1:0]     wr_addr;
    logic [31:0]           wr_data;
    logic [3:0]            wr_strb;
    logic [31:0]           rd_data;
    logic [7:0]            cmd_code;
    logic                  req_cmd;
    logic                  req_par;
    logic                  req_mb;
    logic                  req_val;
    logic [VAL_W-1:0]      val;
    logic [16:0]           mb_start;
    logic [16:0]           mb_cnt;
    logic [PAR_IDX_W-1:0]  idx;
    logic [PAR_IDX_W-1:0]  sel;
    logic                  idx_ok;
    logic [7:0]            val_code;
    logic [7:0]            code;

    function automatic logic [31:0] merge(input logic [31:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [3:0]  strb);
        logic [31:0] m;
        m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
        return (old_v & ~m) | (new_v & m);
    endfunction : merge

    wcec_axil u_axil (
        .aclk    (aclk),
        .aresetn (aresetn),
        .awaddr  (awaddr),
        .awvalid (awvalid),
        .awready (awready),
        .wdata   (wdata),
        .wstrb   (wstrb),
        .wvalid  (wvalid),
        .wready  (wready),
        .bresp   (bresp),
        .bvalid  (bvalid),
        .bready  (bready),
        .araddr  (araddr),
        .arvalid (arvalid),
        .arready (arready),
        .rdata   (rdata),
        .rresp   (rresp),
        .rvalid  (rvalid),
        .rready  (rready),
        .wr_en   (wr_en),
        .wr_addr (wr_addr),
        .wr_data (wr_data),
        .wr_strb (wr_strb),
        .rd_data (rd_data)
    );

    assign req_cmd = wr_en && (wr_addr == OFF_CMD);
    assign req_par = wr_en && (wr_addr == OFF_PARAM);
    assign req_mb  = wr_en && (wr_addr == OFF_MBDAT);
    assign req_val = req_par || req_mb;

    wcec_judge u_judge (
        .req_cmd    (req_cmd),
        .op         (wcec_op_t'(wr_data[2:0])),
        .from_comm  (wr_data[CMD_SRC]),
        .pwr_fail   (st_reg.pf),
        .setup_mode (st_reg.ctrl[CTRL_SETUP]),
        .busy       (st_reg.busy),
        .net_mode   (st_reg.net),
        .stable     (weight_stable),
        .guard      (st_reg.ctrl[CTRL_GUARD]),
        .unipolar   (st_reg.ctrl[CTRL_UNIPOLAR]),
        .gross_neg  (gross_neg),
        .code       (cmd_code)
    );

    // Value checks for panel entries and Modbus register writes
    always_comb begin
        val      = wr_data[VAL_W-1:0];
        mb_start = {1'b0, st_reg.mbadr[15:0]};
        mb_cnt   = {9'h000, st_reg.mbadr[MB_CNT_LSB +: MB_CNT_W]};
        sel      = st_reg.ctrl[CTRL_SEL_LSB +: PAR_IDX_W];
        if (req_mb) begin
            idx = PAR_IDX_W'(mb_start - 17'(MB_BASE));
        end else begin
            idx = wr_data[PAR_IDX_LSB +: PAR_IDX_W];
        end
        idx_ok   = 32'(idx) < NPARAM;
        val_code = ERR_NONE;
        if (req_val) begin
            if (st_reg.pf) begin
                val_code = ERR_STATE;
            end else if (req_mb && (mb_start < 17'(MB_BASE) || mb_start >= MB_END)) begin
                val_code = ERR_START;
            end else if (req_mb && (mb_cnt == 17'h00000 || mb_cnt > 17'(MB_MAX_REGS)
                                    || mb_start + mb_cnt > MB_END)) begin
                val_code = ERR_COUNT;
            end else if (req_mb && wr_data[31:VAL_W] != 16'h0000) begin
                // Modbus registers are 16 bits; anything above is illegal data
                val_code = ERR_FAULTY;
            end else if (req_par && (wr_data[31:PAR_IDX_LSB+PAR_IDX_W] != 13'h0000
                                     || !idx_ok)) begin
                val_code = ERR_FAULTY;
            end else if (val > st_reg.pmax[idx]) begin
                val_code = ERR_HIGH;
            end else if (val < st_reg.pmin[idx]) begin
                val_code = ERR_LOW;
            end
        end
        code = req_cmd ? cmd_code : val_code;
    end

    // Read mux
    always_comb begin
        rd_data = 32'h0000_0000;
        case (araddr)
            OFF_CTRL: begin
                rd_data[CTRL_W-1:0] = st_reg.ctrl;
            end
            OFF_STATUS: begin
                rd_data[ST_PF]     = st_reg.pf;
                rd_data[ST_VALID]  = !st_reg.pf;
                rd_data[ST_NET]    = st_reg.net;
                rd_data[ST_BUSY]   = st_reg.busy;
                rd_data[ST_STABLE] = weight_stable;
            end
            OFF_RESULT: begin
                rd_data[7:0] = st_reg.code;
            end
            OFF_MBADR: begin
                rd_data[MBADR_W-1:0] = st_reg.mbadr;
            end
            OFF_PVAL: begin
                rd_data = {st_reg.pmax[sel], st_reg.pv[sel]};
            end
            default: begin
                rd_data = 32'h0000_0000;
            end
        endcase
    end

    always_comb begin
        st_next     = st_reg;
        st_next.go  = 1'b0;
        st_next.upd = 1'b0;
        st_next.err = 1'b0;
        // Held for the whole undervoltage; weight flagged invalid meanwhile
        st_next.pf  = undervolt;
        st_next.wv  = !undervolt;
        if (cmd_done) begin
            st_next.busy = 1'b0;
        end
        if (wr_en && wr_addr == OFF_CTRL) begin
            st_next.ctrl = CTRL_W'(merge(32'(st_reg.ctrl), wr_data, wr_strb));
        end
        if (wr_en && wr_addr == OFF_MBADR) begin
            st_next.mbadr = MBADR_W'(merge(32'(st_reg.mbadr), wr_data, wr_strb));
        end
        if (wr_en && wr_addr == OFF_LIMIT) begin
            st_next.pmin[sel] = wr_data[15:0];
            st_next.pmax[sel] = wr_data[31:16];
        end
        if (req_cmd || req_val) begin
            st_next.code = code;
            st_next.err  = code != ERR_NONE;
        end
        // Only a clean verdict touches net mode, sets busy or writes parameter values; cmd_done clears busy
        if (req_cmd && code == ERR_NONE) begin
            st_next.go   = 1'b1;
            st_next.op   = wcec_op_t'(wr_data[2:0]);
            st_next.busy = 1'b1;
            if (wr_data[2:0] == OP_NET) begin
                st_next.net = 1'b1;
            end else if (wr_data[2:0] == OP_GROSS) begin
                st_next.net = 1'b0;
            end
        end
        if (req_val && code == ERR_NONE) begin
            st_next.pv[idx] = val;
            st_next.upd     = 1'b1;
            st_next.pidx    = idx;
            st_next.pval_o  = val;
        end
        if (undervolt) begin
            st_next.code = ERR_PWR_FAIL;
        end else if (st_reg.pf && !(req_cmd || req_val)) begin
            st_next.code = ERR_NONE;
        end
        if (!aresetn) begin
            st_next      = '0;
            st_next.ctrl = CTRL_RST;
            st_next.wv   = 1'b1;
            for (int i = 0; i < NPARAM; i++) begin
                st_next.pmax[i] = 16'hffff;
            end
        end
    end

    always_ff @(posedge aclk) begin
        st_reg <= st_next;
    end

    assign pwr_fail     = st_reg.pf;
    assign weight_valid = st_reg.wv;
    assign net_mode     = st_reg.net;
    assign busy         = st_reg.busy;
    assign err_code     = st_reg.code;
    assign err_pulse    = st_reg.err;
    assign cmd_go       = st_reg.go;
    assign cmd_op       = st_reg.op;
    assign param_upd    = st_reg.upd;
    assign param_idx    = st_reg.pidx;
    assign param_val    = st_reg.pval_o;

endmodule : wcec_top

//--- tb/wcec_checker.sv
module wcec_checker
    import wcec_pkg::*;
(
    // Clock and reset
    input wire logic       aclk,
    input wire logic       aresetn,
    // Bus answers
    input wire logic       bvalid,
    input wire logic       bready,
    input wire logic       rvalid,
    input wire logic       rready,
    // Status and verdict
    input wire logic       undervolt,
    input wire logic       pwr_fail,
    input wire logic       weight_valid,
    input wire logic       net_mode,
    input wire logic [7:0] err_code,
    input wire logic       err_pulse,
    input wire logic       cmd_go,
    input wire wcec_op_t   cmd_op,
    input wire logic       param_upd
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence pf_hold;
        undervolt ##1 undervolt;
    endsequence
    sequence pf_gone;
        !undervolt ##1 !undervolt;
    endsequence
    pf_code_a: assert property (pf_hold |-> err_code == ERR_PWR_FAIL && !weight_valid)
        else $error("power fail not shown");
    pf_clear_a: assert property (pf_gone |-> !pwr_fail && weight_valid)
        else $error("power fail stuck");
    rej_code_a: assert property (err_pulse && !pwr_fail |->
        err_code inside {[8'h64:8'h6a], [8'h6e:8'h70]})
        else $error("reject code out of set");
    rej_quiet_a: assert property (err_pulse |-> !cmd_go && !param_upd)
        else $error("rejected request acted");
    rej_net_a: assert property (err_pulse |-> $stable(net_mode))
        else $error("rejected request moved mode");
    net_cause_a: assert property ($changed(net_mode) |->
        cmd_go && cmd_op inside {OP_NET, OP_GROSS})
        else $error("mode changed without command");
    zero_gross_a: assert property (cmd_go && cmd_op == OP_ZERO |-> !net_mode)
        else $error("zero accepted in net mode");
    go_clean_a: assert property (cmd_go |-> err_code == ERR_NONE && !err_pulse)
        else $error("accepted command with code");
    b_hold_a: assert property (bvalid && !bready |=> bvalid)
        else $error("write answer dropped");
    r_hold_a: assert property (rvalid && !rready |=> rvalid)
        else $error("read answer dropped");
endmodule : wcec_checker

//--- tb/wcec_engine.sv
module wcec_engine (
    // Clock and command
    input wire logic aclk,
    input wire logic cmd_go,
    input wire logic slow,
    // Completion
    output logic     cmd_done
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt = 0;
    initial cmd_done = 1'b0;
    // Slow mode keeps a command pending long enough to collide with the next one
    always @(posedge aclk) begin
        cmd_done <= (cnt == 1);
        cnt <= cmd_go ? (slow ? 40 : 2) : (cnt > 0 ? cnt - 1 : 0);
    end
endmodule : wcec_engine

//--- tb/tb_top.sv
module tb_top;
    import wcec_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic undervolt = 0, weight_stable = 1, gross_neg = 0, slow = 0, cmd_done;
    logic awready, wready, bvalid, arready, rvalid, pwr_fail, weight_valid, net_mode, busy;
    logic err_pulse, cmd_go, param_upd;
    logic [7:0] awaddr = 0, araddr = 0, err_code;
    logic [31:0] wdata = 0, rdata;
    logic [3:0] wstrb = 4'hf;
    logic [1:0] bresp, rresp;
    logic [2:0] param_idx;
    logic [15:0] param_val;
    wcec_op_t cmd_op;
    int err_count = 0, comparisons = 0;
    always #4 aclk = ~aclk;
    wcec_top uut (.*);
    wcec_engine eng (.aclk(aclk), .cmd_go(cmd_go), .slow(slow), .cmd_done(cmd_done));
    task automatic results;
        if (err_count == 0 && comparisons > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : results
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            $display("unexpected %s expected %h seen %h", n, e, g);
            err_count++;
        end
    endtask : chk
    task automatic tmo(input int n);
        if (n >= 100) begin
            err_count++;
            results();
        end
    endtask : tmo
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = RESP_OKAY);
        logic aok, wok, bv;
        logic [1:0] br;
        int n;
        @(posedge aclk);
        {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'h7};
        for (n = 0; n < 100; n++) begin
            @(negedge aclk);
            {aok, wok, bv, br} = {awready, wready, bvalid, bresp};
            @(posedge aclk);
            if (aok) awvalid <= 0;
            if (wok) wvalid <= 0;
            if (bv) break;
        end
        tmo(n);
        bready <= 0;
        chk("bresp", r, br);
    endtask : wr
    task automatic rdreg(input logic [7:0] a, logic [31:0] e, logic [1:0] r = RESP_OKAY);
        logic aok, rv;
        logic [31:0] d;
        logic [1:0] rr;
        int n;
        @(posedge aclk);
        {araddr, arvalid, rready} <= {a, 2'h3};
        for (n = 0; n < 100; n++) begin
            @(negedge aclk);
            {aok, rv, d, rr} = {arready, rvalid, rdata, rresp};
            @(posedge aclk);
            if (aok) arvalid <= 0;
            if (rv) break;
        end
        tmo(n);
        rready <= 0;
        chk("rdata", e, d);
        chk("rresp", r, rr);
    endtask : rdreg
    task automatic req(input logic [7:0] a, input logic [31:0] d, input logic [7:0] e);
        wr(a, d);
        @(negedge aclk);
        chk("err_code", e, err_code);
        chk("err_pulse", e != 0, err_pulse);
    endtask : req
    task automatic idle;
        int n;
        for (n = 0; n < 100 && busy !== 0; n++) @(negedge aclk);
        tmo(n);
    endtask : idle
    task automatic t_pfail;
        @(posedge aclk);
        undervolt <= 1;
        repeat (3) @(negedge aclk);
        chk("weight_valid", 32'h2, {pwr_fail, weight_valid});
        req(OFF_CMD, 32'h104, ERR_PWR_FAIL);
        @(posedge aclk);
        undervolt <= 0;
        repeat (3) @(negedge aclk);
        chk("recovery", 32'h2, {err_code, pwr_fail, weight_valid, busy});
    endtask : t_pfail
    task automatic t_modes;
        wr(OFF_CTRL, 32'h4);
        req(OFF_CMD, 32'h101, ERR_STATE);
        wr(OFF_CTRL, 32'h0);
        req(OFF_CMD, 32'h107, ERR_STATE);
        @(posedge aclk);
        weight_stable <= 0;
        req(OFF_CMD, 32'h101, ERR_UNSTABLE);
        req(OFF_CMD, 32'h102, ERR_NONE);
        idle();
        req(OFF_CMD, 32'h105, ERR_NONE);
        idle();
        @(posedge aclk);
        weight_stable <= 1;
        req(OFF_CMD, 32'h101, ERR_NET_MODE);
        chk("net_mode", 1, net_mode);
        req(OFF_CMD, 32'h104, ERR_NONE);
        idle();
        wr(OFF_CTRL, 32'h1);
        @(posedge aclk);
        weight_stable <= 0;
        req(OFF_CMD, 32'h102, ERR_UNSTABLE);
        req(OFF_CMD, 32'h103, ERR_UNSTABLE);
        wr(OFF_CTRL, 32'h2);
        @(posedge aclk);
        {weight_stable, gross_neg} <= 2'h3;
        req(OFF_CMD, 32'h102, ERR_NEG_TARE);
        @(posedge aclk);
        gross_neg <= 0;
    endtask : t_modes
    task automatic t_busy;
        @(posedge aclk);
        slow <= 1;
        req(OFF_CMD, 32'h101, ERR_NONE);
        req(OFF_CMD, 32'h102, ERR_PENDING);
        req(OFF_CMD, 32'h002, ERR_STATE);
        idle();
        req(OFF_CMD, 32'h102, ERR_NONE);
        idle();
        slow <= 0;
    endtask : t_busy
    task automatic t_values;
        wr(OFF_CTRL, 32'h0);
        wr(OFF_LIMIT, 32'h0064000a);
        req(OFF_PARAM, 32'h65, ERR_HIGH);
        req(OFF_PARAM, 32'h09, ERR_LOW);
        req(OFF_PARAM, 32'h8000000a, ERR_FAULTY);
        req(OFF_PARAM, 32'h64, ERR_NONE);
        wr(OFF_MBADR, 32'h00010100);
        req(OFF_MBDAT, 32'h10030, ERR_FAULTY);
        req(OFF_MBDAT, 32'h30, ERR_NONE);
        chk("param", 32'h80030, {param_upd, param_idx, param_val});
        wr(OFF_MBADR, 32'h00010108);
        req(OFF_MBDAT, 32'h40, ERR_START);
        wr(OFF_MBADR, 32'h00020100);
        req(OFF_MBDAT, 32'h40, ERR_COUNT);
        rdreg(OFF_PVAL, 32'h00640030);
        rdreg(8'h40, 32'h0, RESP_SLVERR);
        wr(OFF_STATUS, 32'h1, RESP_SLVERR);
    endtask : t_values
    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1;
        rdreg(OFF_CTRL, 32'h0);
        t_pfail();
        t_modes();
        t_busy();
        t_values();
        results();
    end
endmodule : tb_top
bind wcec_top wcec_checker chk (.*);
